// ===== hdl/vr_fault_cfg.svh
// constants of the fault supervisor: codes, counts and timing
// assumes: included by bare name from the package and the design modules
`ifndef VR_FAULT_CFG_SVH
`define VR_FAULT_CFG_SVH

// ----------------------------------------------------------------------
// codes and widths
// ----------------------------------------------------------------------
`define VR_NUM_PHASES       4
`define VR_VID_WIDTH        6
`define VR_VID_NO_LOAD      6'h3f
`define VR_SYNC_WIDTH       21

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define VR_CLK_PERIOD_NS    100
`define VR_REACT_NS         20
`define VR_REACT_CYCLES     (((`VR_REACT_NS) / (`VR_CLK_PERIOD_NS)) < 1 ? 1 : ((`VR_REACT_NS) / (`VR_CLK_PERIOD_NS)))
`define VR_PHASE_OC_CYCLES  4'h8
`define VR_OC_WAIT_CYCLES   13'h1000

`endif

// ===== hdl/vr_fault_pkg.sv
// types of the fault supervisor: controller states and trip level choices
// assumes: constants come from vr_fault_cfg.svh
`include "vr_fault_cfg.svh"

package vr_fault_pkg;

   // ----------------------------------------------------------------------
   // controller states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_SHUTDOWN,
      ST_SOFTSTART,
      ST_RUN,
      ST_OC_WAIT,
      ST_OV_LATCH
   } ctrl_state_t;

   // ----------------------------------------------------------------------
   // overvoltage trip level selected for the analog comparator
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      OVL_OFF,
      OVL_AUX_1V8,
      OVL_FIXED_1V7,
      OVL_VID_PLUS_200M,
      OVL_MAX_1V5_VID_200M
   } ov_level_t;

   typedef logic [`VR_VID_WIDTH-1:0]  vid_t;
   typedef logic [`VR_NUM_PHASES-1:0] phase_vec_t;

endpackage

// ===== hdl/vr_fault_supervisor.sv
// fault supervisor: power good, overvoltage latch, overcurrent hiccup, driver enable
// assumes: analog comparators and enable pins arrive asynchronously;
// soft-start sequencer and switching tick share i_clk_sys
`timescale 1ns/1ps
`include "vr_fault_cfg.svh"

// Functional notes
// (R1) power good low in shutdown, high after soft-start
// (R2) power good drops only on undervoltage or disable
// (R3) overvoltage alone never drops power good
// (R4) below 75% of VOLTAGE_ID_CODE flags undervoltage
// (R5) aux monitor trips above 1.8V before valid supply
// (R6) valid supply, not enabled: trip at 1.7V
// (R7) after overvoltage latch: trip at VOLTAGE_ID_CODE plus 200mV
// (R8) soft-start: trip at max of 1.5V, VOLTAGE_ID_CODE+200mV
// (R9) after soft-start: trip at VOLTAGE_ID_CODE plus 200mV
// (R10) overvoltage forces phases low until output discharged
// (R11) phases low until DAC level, then high impedance
// (R12) every overvoltage recurrence forces phases low again
// (R13) crowbar fires together with the forced low
// (R14) overvoltage latch cleared only by enables or supply
// (R15) average overcurrent shuts converter down at once
// (R16) phase overcurrent eight consecutive cycles shuts down
// (R17) overcurrent tri-states phases for 4096 switching cycles
// (R18) still enabled after wait: retry soft-start
// (R19) driver enable rises when soft-start ramp begins
// (R20) overcurrent drops driver enable immediately
// (R21) driver enable held in overvoltage until 0.6V
// (R22) all-ones VOLTAGE_ID_CODE code forces shutdown
// (R23) enabled only with supply, both enables, valid VOLTAGE_ID_CODE
// (R24) comparator results synchronised before use
module vr_fault_supervisor
   import vr_fault_pkg::*;
(
   // clock and reset
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_reset,
   // supply and enable pins
   input  wire logic                    i_supply_por_ok,
   input  wire logic                    i_supply_above_aux,
   input  wire logic                    i_analog_enable_ok,
   input  wire logic                    i_logic_level_enable_in,
   input  wire vr_fault_pkg::vid_t      i_voltage_id_code,
   // analog comparator results
   input  wire logic                    i_undervoltage,
   input  wire logic                    i_overvoltage,
   input  wire logic                    i_avg_overcurrent,
   input  wire vr_fault_pkg::phase_vec_t i_phase_overcurrent,
   input  wire logic                    i_out_below_0v6,
   input  wire logic                    i_out_below_1v5,
   input  wire logic                    i_diff_at_dac,
   // soft-start sequencer and switching tick
   input  wire logic                    i_switch_tick,
   input  wire logic                    i_ss_ramp_begun,
   input  wire logic                    i_ss_done,
   // power good open-drain pin
   input  wire logic                    i_power_ok_out_i,
   output logic                         o_power_ok_out_o,
   output logic                         o_power_ok_out_oe_n,
   output logic                         o_power_ok_level,
   // phase and driver control
   output logic                         o_phase_force_low,
   output logic                         o_phase_tristate,
   output logic                         o_gate_driver_enable_out,
   output logic                         o_crowbar_drive_out,
   // analog and sequencer control
   output vr_fault_pkg::ov_level_t      o_ov_level_sel,
   output logic                         o_softstart_start,
   output logic                         o_converter_run,
   output vr_fault_pkg::ctrl_state_t    o_state
);

   // ----------------------------------------------------------------------
   // input synchronisation
   // ----------------------------------------------------------------------
   logic [`VR_SYNC_WIDTH-1:0] sync_out;
   logic                      por_s;
   logic                      aux_s;
   logic                      en_s;
   logic                      ll_s;
   vid_t                      vid_s;
   logic                      uv_s;
   logic                      ov_s;
   logic                      avg_oc_s;
   phase_vec_t                ph_oc_s;
   logic                      below06_s;
   logic                      below15_s;
   logic                      dac_s;
   logic                      pg_pin_s;

   // every comparator and pin passes two flops
   vr_sync_bank #(
      .WIDTH (`VR_SYNC_WIDTH)
   ) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_async   ({i_supply_por_ok, i_supply_above_aux, i_analog_enable_ok, i_logic_level_enable_in,
                   i_voltage_id_code, i_undervoltage, i_overvoltage, i_avg_overcurrent,
                   i_phase_overcurrent, i_out_below_0v6, i_out_below_1v5, i_diff_at_dac,
                   i_power_ok_out_i}), // see (R24)
      .o_sync    (sync_out)
   );

   assign {por_s, aux_s, en_s, ll_s, vid_s, uv_s, ov_s, avg_oc_s, ph_oc_s,
           below06_s, below15_s, dac_s, pg_pin_s} = sync_out;

   // ----------------------------------------------------------------------
   // enable decode and fault qualifiers
   // ----------------------------------------------------------------------
   ctrl_state_t state_q;
   logic        ov_prev_q;
   logic        pins_ok;
   logic        en_now;
   logic        ov_armed;
   logic        ov_onset;
   logic        latch_clear;
   logic        phase_trip;
   logic        oc_trip;
   logic        discharged;
   logic        wait_done;

   // supply and both enables; VOLTAGE_ID_CODE code adds the no-load check
   assign pins_ok     = por_s && en_s && ll_s; // see (R23)
   assign en_now      = pins_ok && (vid_s != `VR_VID_NO_LOAD); // see (R22) see (R23)
   // aux monitor covers the window before a valid supply
   assign ov_armed    = por_s || aux_s; // see (R5)
   assign ov_onset    = ov_armed && ov_s && !ov_prev_q; // see (R12)
   // vid code deliberately left out of the clear
   assign latch_clear = !pins_ok; // see (R14)
   assign oc_trip     = avg_oc_s || phase_trip; // see (R15) see (R16)
   assign discharged  = por_s ? below06_s : below15_s; // see (R10)

   // per-phase persistence counters, armed only while switching
   vr_phase_oc_count u_phase_oc (
      .i_clk_sys  (i_clk_sys),
      .i_reset    (i_reset),
      .i_tick     (i_switch_tick),
      .i_arm      (state_q == ST_SOFTSTART || state_q == ST_RUN),
      .i_phase_oc (ph_oc_s),
      .o_trip     (phase_trip)
   );

   // ----------------------------------------------------------------------
   // controller state and fault state
   // ----------------------------------------------------------------------
   ctrl_state_t state_d;
   logic [12:0] wait_cnt_d;
   logic [12:0] wait_cnt_q;
   logic        ov_prev_d;
   logic        ov_latched_d;
   logic        ov_latched_q;
   logic        force_low_d;
   logic        force_low_q;
   logic        crowbar_d;
   logic        crowbar_q;
   logic        ss_passed_d;
   logic        ss_passed_q;
   logic        pg_d;
   logic        pg_q;
   logic        drv_d;
   logic        drv_q;
   logic        tri_d;
   logic        tri_q;
   logic        ss_start_d;
   logic        ss_start_q;
   ov_level_t   level_d;
   ov_level_t   level_q;

   assign wait_done = (state_q == ST_OC_WAIT) && i_switch_tick &&
                      (wait_cnt_q == `VR_OC_WAIT_CYCLES - 13'h1);

   // next state: overvoltage takes priority over everything
   always_comb begin
      state_d    = state_q;
      wait_cnt_d = 13'h0;
      case (state_q)
         ST_SHUTDOWN: begin
            if (en_now) begin
               state_d = ST_SOFTSTART;
            end
         end
         ST_SOFTSTART: begin
            if (!en_now) begin
               state_d = ST_SHUTDOWN; // see (R22)
            end else if (oc_trip) begin
               state_d = ST_OC_WAIT; // see (R15) see (R16)
            end else if (i_ss_done) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!en_now) begin
               state_d = ST_SHUTDOWN; // see (R22)
            end else if (oc_trip) begin
               state_d = ST_OC_WAIT; // see (R15) see (R16)
            end
         end
         ST_OC_WAIT: begin
            wait_cnt_d = wait_cnt_q + {12'h0, i_switch_tick}; // see (R17)
            if (wait_done) begin
               state_d = en_now ? ST_SOFTSTART : ST_SHUTDOWN; // see (R18)
            end
         end
         ST_OV_LATCH: begin
            if (latch_clear) begin
               state_d = ST_SHUTDOWN; // see (R14)
            end
         end
         default: begin
            state_d = ST_SHUTDOWN;
         end
      endcase
      if (ov_onset || (ov_latched_q && !latch_clear)) begin
         state_d = ST_OV_LATCH; // see (R14)
      end
   end

   // overvoltage latch, forced-low and crowbar; set wins over clear
   always_comb begin
      ov_prev_d    = ov_armed && ov_s;
      ov_latched_d = ov_onset || (ov_latched_q && !latch_clear); // see (R14)
      crowbar_d    = ov_onset || (crowbar_q && !latch_clear); // see (R13)
      force_low_d  = force_low_q;
      if (ov_onset) begin
         force_low_d = 1'b1; // see (R10) see (R12)
      end else if (force_low_q && (dac_s || discharged || latch_clear)) begin
         force_low_d = 1'b0; // see (R11) see (R14)
      end
   end

   // power good, driver enable and phase tri-state
   always_comb begin
      ss_passed_d = ss_passed_q;
      if (!en_now) begin
         ss_passed_d = 1'b0; // see (R1)
      end else if (state_q == ST_SOFTSTART && i_ss_done && !oc_trip) begin
         ss_passed_d = 1'b1; // see (R1)
      end
      // overvoltage is deliberately absent here
      pg_d = en_now && ss_passed_q && !uv_s; // see (R2) see (R3) see (R4)
      case (state_d)
         ST_SOFTSTART: drv_d = drv_q || i_ss_ramp_begun; // see (R19)
         ST_RUN:       drv_d = 1'b1;
         ST_OV_LATCH:  drv_d = drv_q && !below06_s; // see (R21)
         default:      drv_d = 1'b0; // see (R20)
      endcase
      case (state_d)
         ST_SOFTSTART: tri_d = 1'b0;
         ST_RUN:       tri_d = 1'b0;
         ST_OV_LATCH:  tri_d = !force_low_d; // see (R11)
         default:      tri_d = 1'b1; // see (R17)
      endcase
      ss_start_d = (state_d == ST_SOFTSTART) && (state_q != ST_SOFTSTART); // see (R18)
   end

   // trip level for the analog overvoltage comparator
   always_comb begin
      if (!por_s) begin
         level_d = aux_s ? OVL_AUX_1V8 : OVL_OFF; // see (R5)
      end else if (ov_latched_q) begin
         level_d = OVL_VID_PLUS_200M; // see (R7)
      end else begin
         case (state_q)
            ST_SOFTSTART: level_d = OVL_MAX_1V5_VID_200M; // see (R8)
            ST_OC_WAIT:   level_d = OVL_MAX_1V5_VID_200M;
            ST_RUN:       level_d = OVL_VID_PLUS_200M; // see (R9)
            default:      level_d = OVL_FIXED_1V7; // see (R6)
         endcase
      end
   end

   // registers
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state_q      <= ST_SHUTDOWN;
         wait_cnt_q   <= 13'h0;
         ov_prev_q    <= 1'b0;
         ov_latched_q <= 1'b0;
         force_low_q  <= 1'b0;
         crowbar_q    <= 1'b0;
         ss_passed_q  <= 1'b0;
         pg_q         <= 1'b0;
         drv_q        <= 1'b0;
         tri_q        <= 1'b1;
         ss_start_q   <= 1'b0;
         level_q      <= OVL_OFF;
      end else begin
         state_q      <= state_d;
         wait_cnt_q   <= wait_cnt_d;
         ov_prev_q    <= ov_prev_d;
         ov_latched_q <= ov_latched_d;
         force_low_q  <= force_low_d;
         crowbar_q    <= crowbar_d;
         ss_passed_q  <= ss_passed_d;
         pg_q         <= pg_d;
         drv_q        <= drv_d;
         tri_q        <= tri_d;
         ss_start_q   <= ss_start_d;
         level_q      <= level_d;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign o_power_ok_out_o         = 1'b0;
   assign o_power_ok_out_oe_n      = pg_q; // released when good
   assign o_power_ok_level         = pg_pin_s;
   assign o_phase_force_low        = force_low_q;
   assign o_phase_tristate         = tri_q;
   assign o_gate_driver_enable_out = drv_q;
   assign o_crowbar_drive_out      = crowbar_q;
   assign o_ov_level_sel           = level_q;
   assign o_softstart_start        = ss_start_q;
   assign o_converter_run          = (state_q == ST_SOFTSTART) || (state_q == ST_RUN);
   assign o_state                  = state_q;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   sequence s_oc_trip_in_run;
      (state_q == ST_RUN) && en_now && oc_trip && !ov_onset && !ov_latched_q;
   endsequence

   sequence s_oc_shut;
      (state_q == ST_OC_WAIT) && tri_q && !drv_q;
   endsequence

   chk_pg_disable_low: assert property (!en_now |=> !pg_q) // see (R1) see (R2)
      else $error("power good high while disabled");
   chk_pg_uv_low: assert property (uv_s |=> !pg_q) // see (R4)
      else $error("power good high during undervoltage");
   chk_pg_ov_keeps: assert property (pg_q && ov_onset && en_now && !uv_s |=> pg_q) // see (R3)
      else $error("overvoltage dropped power good");
   chk_noload_shuts: assert property ((state_q == ST_RUN) && por_s && en_s && ll_s && // see (R22)
                                      (vid_s == `VR_VID_NO_LOAD) && !ov_onset |=> state_q == ST_SHUTDOWN)
      else $error("no-load code did not shut down");
   chk_ov_force_crowbar: assert property (ov_onset |=> force_low_q && crowbar_q && !tri_q) // see (R10) see (R13)
      else $error("overvoltage onset did not force low and fire crowbar");
   chk_ov_latch_hold: assert property (ov_latched_q && pins_ok |=> ov_latched_q && state_q == ST_OV_LATCH) // see (R14)
      else $error("overvoltage latch released without enable cycle");
   chk_ov_release_hiz: assert property (force_low_q && dac_s && !ov_onset |=> !force_low_q && tri_q) // see (R11)
      else $error("phases not released to high impedance");
   chk_oc_shutdown: assert property (s_oc_trip_in_run |=> s_oc_shut) // see (R15) see (R17) see (R20)
      else $error("overcurrent did not tri-state and drop driver enable");
   chk_oc_wait_hold: assert property ((state_q == ST_OC_WAIT) && !wait_done && !ov_onset // see (R17)
                                      |=> state_q == ST_OC_WAIT)
      else $error("overcurrent wait ended early");
   chk_oc_retry: assert property (wait_done && en_now && !ov_onset // see (R18)
                                  |=> (state_q == ST_SOFTSTART) && ss_start_q)
      else $error("no soft-start retry after wait");
   chk_drv_ramp_rise: assert property ((state_q == ST_SOFTSTART) && en_now && !oc_trip && !ov_onset // see (R19)
                                       && i_ss_ramp_begun |=> drv_q)
      else $error("driver enable not raised at ramp start");
   chk_drv_ov_hold: assert property (drv_q && ov_onset && !below06_s // see (R21)
                                     |=> drv_q ##1 (drv_q || $past(below06_s)))
      else $error("driver enable dropped during overvoltage");
   chk_level_softstart: assert property ((state_q == ST_SOFTSTART) && por_s && !ov_latched_q // see (R8)
                                         |=> level_q == OVL_MAX_1V5_VID_200M)
      else $error("wrong soft-start trip level");

endmodule

// ===== hdl/vr_phase_oc_count.sv
// per-phase overcurrent persistence counters on switching ticks
// assumes: tick is a one-cycle pulse per switching cycle, same clock
`timescale 1ns/1ps
`include "vr_fault_cfg.svh"

module vr_phase_oc_count
   import vr_fault_pkg::*;
(
   // clock and reset
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_reset,
   // sampling control
   input  wire logic                    i_tick,
   input  wire logic                    i_arm,
   input  wire vr_fault_pkg::phase_vec_t i_phase_oc,
   // result
   output logic                         o_trip
);

   logic [`VR_NUM_PHASES-1:0] hit;

   // one counter per phase
   for (genvar p = 0; p < `VR_NUM_PHASES; p++) begin : g_phase
      logic [3:0] cnt_d;
      logic [3:0] cnt_q;

      // count consecutive ticks above reference, restart when it drops
      always_comb begin
         cnt_d = cnt_q;
         if (!i_arm || !i_phase_oc[p]) begin
            cnt_d = 4'h0; // see (R16)
         end else if (i_tick && cnt_q != `VR_PHASE_OC_CYCLES) begin
            cnt_d = cnt_q + 4'h1; // see (R16)
         end
      end

      always_ff @(posedge i_clk_sys) begin
         if (i_reset) begin
            cnt_q <= 4'h0;
         end else begin
            cnt_q <= cnt_d;
         end
      end

      assign hit[p] = (cnt_q == `VR_PHASE_OC_CYCLES);
   end

   assign o_trip = |hit;

endmodule

// ===== hdl/vr_sync_bank.sv
// two-flop synchroniser bank for pin and comparator levels
// assumes: inputs are slow levels from outside the clock domain
`timescale 1ns/1ps

module vr_sync_bank #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_reset,
   // levels
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;

   // first stage feeds only the second
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         stage1_q <= '0;
         stage2_q <= '0;
      end else begin
         stage1_q <= i_async;
         stage2_q <= stage1_q;
      end
   end

   assign o_sync = stage2_q;

endmodule

// ===== tb/vr_far_side_model.sv
// far side: power-good wire with pull-up and gate driver phase node
// assumes: fed straight from the supervisor outputs, no clock needed
`timescale 1ns/1ps

module vr_far_side_model (
   // supervisor side
   input  wire logic       i_pg_oe_n,
   input  wire logic       i_pg_o,
   input  wire logic       i_force_low,
   input  wire logic       i_tristate,
   input  wire logic       i_drv,
   // wire and driver state
   output logic            o_pg_wire,
   output logic [1:0]      o_phase_node
);
   // ----------------------------------------------------------------------
   // open-drain wire with pull-up, driver decode
   // ----------------------------------------------------------------------
   // released pin floats to the pull-up level
   assign o_pg_wire = i_pg_oe_n ? 1'b1 : i_pg_o;
   // 0 lower fet on, 1 both off, 2 switching
   always_comb begin
      if (!i_drv || i_tristate) o_phase_node = 2'h1;
      else if (i_force_low) o_phase_node = 2'h0;
      else o_phase_node = 2'h2;
   end
endmodule

// ===== tb/vr_fault_supervisor_tb_top.sv
// bench of the fault supervisor: random vid and phase, hand-written faults
// assumes: async levels driven on falling edges, 2 sync flops + 1 register
`timescale 1ns/1ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end

module vr_fault_supervisor_tb_top;
   import vr_fault_pkg::*;
   // ----------------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------------
   logic        clk, rst, por, aux, en, ll, uv, ov, aoc, b06, b15, dac, tick, ramp, done, tick_en, pg_wire;
   vid_t        voltage_id_code;
   phase_vec_t  poc;
   logic        pg_o, pg_oe_n, pg_lvl, force_low, tris, drv, crow, ss_start, run;
   logic [1:0]  node;
   ov_level_t   lvl;
   ctrl_state_t st;
   logic [15:0] rnd;
   int          n_fail, num_checks, oc_ticks;

   vr_fault_supervisor vr_fault_supervisor_inst (
      .i_clk_sys(clk), .i_reset(rst), .i_supply_por_ok(por), .i_supply_above_aux(aux),
      .i_analog_enable_ok(en), .i_logic_level_enable_in(ll), .i_voltage_id_code(voltage_id_code),
      .i_undervoltage(uv), .i_overvoltage(ov), .i_avg_overcurrent(aoc), .i_phase_overcurrent(poc),
      .i_out_below_0v6(b06), .i_out_below_1v5(b15), .i_diff_at_dac(dac), .i_switch_tick(tick),
      .i_ss_ramp_begun(ramp), .i_ss_done(done), .i_power_ok_out_i(pg_wire), .o_power_ok_out_o(pg_o),
      .o_power_ok_out_oe_n(pg_oe_n), .o_power_ok_level(pg_lvl), .o_phase_force_low(force_low),
      .o_phase_tristate(tris), .o_gate_driver_enable_out(drv), .o_crowbar_drive_out(crow),
      .o_ov_level_sel(lvl), .o_softstart_start(ss_start), .o_converter_run(run), .o_state(st));

   vr_far_side_model vr_far_side_model_inst (
      .i_pg_oe_n(pg_oe_n), .i_pg_o(pg_o), .i_force_low(force_low), .i_tristate(tris),
      .i_drv(drv), .o_pg_wire(pg_wire), .o_phase_node(node));

   // ----------------------------------------------------------------------
   // clock, switching tick and tick count in overcurrent wait
   // ----------------------------------------------------------------------
   always #50 clk = ~clk;
   always @(negedge clk) if (tick_en) tick <= ~tick;
   always @(posedge clk) if (st === ST_OC_WAIT && tick) oc_ticks = oc_ticks + 1;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // bounded wait for a controller state
   task automatic wait_st(input ctrl_state_t s, input int lim);
      int k;
      for (k = 0; k < lim && st !== s; k++) @(negedge clk);
      if (st !== s) begin
         n_fail++;
         $display("MISMATCH wait state exp %0h got %0h", s, st);
         end_sim();
      end
   endtask

   // soft-start through to run
   task automatic finish_ss();
      done = 1'b1;
      wait_st(ST_RUN, 4);
      done = 1'b0;
      cyc(3);
   endtask

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      {clk, por, aux, en, ll, uv, ov, aoc, b06, b15, dac, tick, ramp, done, tick_en} = '0;
      rst        = 1'b1;
      voltage_id_code        = '0;
      poc        = '0;
      rnd        = 16'h0004;
      n_fail     = 0;
      num_checks = 0;
      oc_ticks   = 0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      cyc(1);
      `CHK("pg oe_n", 1'b0, pg_oe_n)
      `CHK("pg data", 1'b0, pg_o)
      `CHK("tristate", 1'b1, tris)
      `CHK("drv", 1'b0, drv)
      `CHK("level", OVL_OFF, lvl)
      aux = 1'b1;
      cyc(4);
      `CHK("level aux", OVL_AUX_1V8, lvl)
      por = 1'b1;
      b15 = 1'b1;
      cyc(4);
      `CHK("level fixed", OVL_FIXED_1V7, lvl)
      voltage_id_code = `VR_VID_NO_LOAD;
      en  = 1'b1;
      ll  = 1'b1;
      cyc(4);
      `CHK("no-load", ST_SHUTDOWN, st)
      rnd = lfsr(rnd);
      voltage_id_code = (rnd[5:0] == 6'h3f) ? 6'h15 : rnd[5:0];
      wait_st(ST_SOFTSTART, 6);
      `CHK("ss start", 1'b1, ss_start)
      `CHK("run", 1'b1, run)
      cyc(2);
      `CHK("level ss", OVL_MAX_1V5_VID_200M, lvl)
      `CHK("drv pre ramp", 1'b0, drv)
      ramp = 1'b1;
      cyc(2);
      `CHK("drv ramp", 1'b1, drv)
      finish_ss();
      `CHK("pg up", 1'b1, pg_oe_n)
      `CHK("level run", OVL_VID_PLUS_200M, lvl)
      `CHK("node run", 2'h2, node)
      // pin drops after 3 edges, wire level seen 2 flops later
      uv = 1'b1;
      cyc(6);
      `CHK("pg uv", 1'b0, pg_oe_n)
      `CHK("pg wire", 1'b0, pg_lvl)
      uv = 1'b0;
      cyc(4);
      `CHK("pg after uv", 1'b1, pg_oe_n)
      // average overcurrent and hiccup retry
      aoc = 1'b1;
      cyc(4);
      `CHK("avg oc", ST_OC_WAIT, st)
      `CHK("oc tris", 1'b1, tris)
      `CHK("oc drv", 1'b0, drv)
      `CHK("oc node", 2'h1, node)
      `CHK("oc pg", 1'b1, pg_oe_n)
      aoc      = 1'b0;
      oc_ticks = 0;
      tick_en  = 1'b1;
      wait_st(ST_SOFTSTART, 9000);
      `CHK("oc wait ticks", 4096, oc_ticks)
      `CHK("retry pulse", 1'b1, ss_start)
      finish_ss();
      // phase overcurrent: broken runs do not trip, eight ticks do
      rnd = lfsr(rnd);
      poc[rnd[1:0]] = 1'b1;
      cyc(12);
      poc = '0;
      cyc(4);
      poc[rnd[1:0]] = 1'b1;
      cyc(12);
      `CHK("phase short", ST_RUN, st)
      wait_st(ST_OC_WAIT, 24);
      poc = '0;
      ll  = 1'b0;
      wait_st(ST_SHUTDOWN, 9000);
      `CHK("pg disabled", 1'b0, pg_oe_n)
      ll = 1'b1;
      wait_st(ST_SOFTSTART, 6);
      finish_ss();
      // overvoltage latch, release, recurrence, discharge, clear
      ov = 1'b1;
      cyc(4);
      `CHK("ov low", 1'b1, force_low)
      `CHK("ov node", 2'h0, node)
      `CHK("crowbar", 1'b1, crow)
      `CHK("ov pg", 1'b1, pg_oe_n)
      `CHK("ov drv", 1'b1, drv)
      ov = 1'b0;
      cyc(2);
      `CHK("level latch", OVL_VID_PLUS_200M, lvl)
      dac = 1'b1;
      cyc(4);
      `CHK("release low", 1'b0, force_low)
      `CHK("release tris", 1'b1, tris)
      `CHK("release node", 2'h1, node)
      dac = 1'b0;
      ov  = 1'b1;
      cyc(4);
      `CHK("recur low", 1'b1, force_low)
      ov  = 1'b0;
      b06 = 1'b1;
      cyc(4);
      `CHK("discharged drv", 1'b0, drv)
      `CHK("discharged low", 1'b0, force_low)
      voltage_id_code = `VR_VID_NO_LOAD;
      cyc(4);
      `CHK("vid no clear", ST_OV_LATCH, st)
      `CHK("pg no-load", 1'b0, pg_oe_n)
      en = 1'b0;
      cyc(4);
      `CHK("latch clear", ST_SHUTDOWN, st)
      `CHK("crowbar off", 1'b0, crow)
      end_sim();
   end
endmodule
